// ### bwo_consts.svh
// register indices, field positions, reset values and widths
`ifndef BWO_CONSTS_SVH
`define BWO_CONSTS_SVH

// ==========================================================
// register indices on the indexed graphics port
`define BWO_IDX_MAP_SELECT 8'h06
`define BWO_IDX_OFFSET_ZERO 8'h09
`define BWO_IDX_OFFSET_ONE 8'h0a
`define BWO_IDX_MODE_EXT 8'h0b

// ==========================================================
// field positions
`define BWO_MAP_SEL_HI 3
`define BWO_MAP_SEL_LO 2
`define BWO_EXT_SECOND_EN 0
`define BWO_EXT_GRAN_SEL 5
`define BWO_EXT_MASK 8'h3f

// ==========================================================
// reset values
`define BWO_RST_OFFSET 8'h00
`define BWO_RST_MAP_SEL 2'h0
`define BWO_RST_MODE_EXT 8'h00

// ==========================================================
// address layout
`define BWO_ADDR_W 22
`define BWO_PAGE_LSB 12
`define BWO_HOST_BIT15 15

`endif

// ### bwo_pkg.sv
// types shared by the banked window offset logic
package bwo_pkg;

  typedef logic [7:0] bwo_byte_t;
  typedef logic [21:0] bwo_addr_t;

  // one-hot offset alignment
  typedef enum logic [1:0] {
    BWO_ALIGN_4K = 2'b01,
    BWO_ALIGN_16K = 2'b10
  } bwo_align_t;

endpackage

// ### bwo_xlate.sv
// combinational window address plus offset adder
`timescale 1ns/1ps
`include "bwo_consts.svh"

module bwo_xlate (
  // host side
  input wire logic [21:0] host_address_i,
  input wire logic keep_bit15_i,
  input wire bwo_pkg::bwo_align_t align_i,
  input wire logic [7:0] offset_i,
  // memory side
  output logic [21:0] display_memory_address_o
);

  logic [16:0] intermediate_window_address;
  logic [7:0] sum_4k;
  logic [9:0] sum_16k;
  logic [9:0] page;

  // bit 16 is always forced low; bit 15 only survives in one case
  assign intermediate_window_address = {1'b0,
    keep_bit15_i & host_address_i[15], host_address_i[14:0]};

  // 4k steps: offset bit 0 lands on address bit 12
  assign sum_4k = {3'h0, intermediate_window_address[16:12]}
                  + offset_i;

  // 16k steps: offset shifted up two, only bits 6:0 count
  assign sum_16k = {5'h00, intermediate_window_address[16:12]}
                   + {1'b0, offset_i[6:0], 2'h0};

  assign page = (align_i == bwo_pkg::BWO_ALIGN_16K) ?
                sum_16k : {2'h0, sum_4k};

  assign display_memory_address_o =
    {page, host_address_i[11:0]};

endmodule

// ### bwo_window.sv
// banked display memory window: offset registers and address translation
// Operation
// - offset zero is the one added unless second on and bit 15 set.
// - 4k granularity: first offset reaches 1 Mbyte in 4k steps.
// - granularity select one: offset bits 6:0 add at 20:14, 16k steps.
// - memory address is window address plus selected offset, wrapped to the adder width.
// - 64k map, second offset off: bit 16 zero, bit 15 from host.
// - otherwise bits 16 and 15 forced zero, bits 14:0 pass through.
// - at 4k alignment offset bit 0 adds at address bit 12.
// - second enabled and host bit 15 high selects the second offset.
// - at 16k alignment offset shifts up two, result spans bits 21:12.
`timescale 1ns/1ps
`include "bwo_consts.svh"

module bwo_window #(
  parameter int ADDR_W = `BWO_ADDR_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // indexed register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_index_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // host access
  input wire logic host_req_i,
  input wire logic [ADDR_W-1:0] host_address_i,
  // display memory request
  output logic mem_req_o,
  output logic [ADDR_W-1:0] display_memory_address_o
);

  // ==========================================================
  // parameter check
  if (ADDR_W != 22) begin : g_bad_width
    $error("ADDR_W must be 22");
  end

  // ==========================================================
  // reset synchroniser
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ==========================================================
  // registers
  bwo_pkg::bwo_byte_t window_offset_zero_q;
  bwo_pkg::bwo_byte_t window_offset_one_q;
  bwo_pkg::bwo_byte_t graphics_mode_extension_q;
  logic [1:0] memory_map_select_q;

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] sel);
    hit = (idx == sel);
  endfunction

  wire wr_off0 = reg_wr_i && hit(reg_index_i, `BWO_IDX_OFFSET_ZERO);
  wire wr_off1 = reg_wr_i && hit(reg_index_i, `BWO_IDX_OFFSET_ONE);
  wire wr_ext = reg_wr_i && hit(reg_index_i, `BWO_IDX_MODE_EXT);
  wire wr_map = reg_wr_i && hit(reg_index_i, `BWO_IDX_MAP_SELECT);

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      window_offset_zero_q <= `BWO_RST_OFFSET;
      window_offset_one_q <= `BWO_RST_OFFSET;
      graphics_mode_extension_q <= `BWO_RST_MODE_EXT;
      memory_map_select_q <= `BWO_RST_MAP_SEL;
    end else begin
      if (wr_off0) window_offset_zero_q <= reg_wdata_i;
      if (wr_off1) window_offset_one_q <= reg_wdata_i;
      if (wr_ext) graphics_mode_extension_q <= reg_wdata_i & `BWO_EXT_MASK;
      if (wr_map) memory_map_select_q <=
        reg_wdata_i[`BWO_MAP_SEL_HI:`BWO_MAP_SEL_LO];
    end
  end

  // ==========================================================
  // readback; unmapped indices and reserved bits read zero
  logic [7:0] rd_mux;

  assign rd_mux =
    hit(reg_index_i, `BWO_IDX_OFFSET_ZERO) ? window_offset_zero_q :
    hit(reg_index_i, `BWO_IDX_OFFSET_ONE) ? window_offset_one_q :
    hit(reg_index_i, `BWO_IDX_MODE_EXT) ? graphics_mode_extension_q :
    hit(reg_index_i, `BWO_IDX_MAP_SELECT) ?
      {4'h0, memory_map_select_q, 2'h0} : 8'h00;

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) reg_rdata_o <= rd_mux;
    end
  end

  // ==========================================================
  // window configuration decode
  wire second_offset_enable =
    graphics_mode_extension_q[`BWO_EXT_SECOND_EN];
  wire granularity_select = graphics_mode_extension_q[`BWO_EXT_GRAN_SEL];
  wire map_64k = (memory_map_select_q == 2'h0) ||
                 (memory_map_select_q == 2'h1);
  wire keep_bit15 = map_64k && !second_offset_enable;
  wire use_second = second_offset_enable &&
                    host_address_i[`BWO_HOST_BIT15];
  wire [7:0] sel_offset = use_second ? window_offset_one_q :
                          window_offset_zero_q;
  bwo_pkg::bwo_align_t align;
  assign align = granularity_select ? bwo_pkg::BWO_ALIGN_16K :
                 bwo_pkg::BWO_ALIGN_4K;

  logic [21:0] display_memory_address;

  bwo_xlate u_xlate (
    .host_address_i(host_address_i),
    .keep_bit15_i(keep_bit15),
    .align_i(align),
    .offset_i(sel_offset),
    .display_memory_address_o(display_memory_address)
  );

  // ==========================================================
  // registered memory request
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mem_req_o <= 1'b0;
      display_memory_address_o <= '0;
    end else begin
      mem_req_o <= host_req_i;
      if (host_req_i) begin
        display_memory_address_o <= display_memory_address;
      end
    end
  end

  // ==========================================================
  // assertions
  low_bits_pass_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    host_req_i |=> display_memory_address_o[11:0] ==
      $past(host_address_i[11:0]))
    else $error("low address bits altered");

  first_offset_4k_a: assert property (@(posedge clk_i)
    disable iff (!rst_n_q)
    host_req_i && !granularity_select && !second_offset_enable
    && !wr_ext && !wr_off0 && !wr_map
    |=> display_memory_address_o[19:12] ==
      8'({3'h0, 1'b0, $past(map_64k) & $past(host_address_i[15]),
          $past(host_address_i[14:12])} + $past(window_offset_zero_q))
    )
    else $error("first offset sum wrong at 4k");

  reach_4k_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    host_req_i && !granularity_select
    |=> display_memory_address_o[21:20] == 2'h0)
    else $error("4k window beyond 1 Mbyte");

  gran_16k_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    host_req_i && granularity_select && !second_offset_enable
    && !map_64k
    |=> display_memory_address_o[21:12] ==
      10'({$past(host_address_i[14:12])}
          + {$past(window_offset_zero_q[6:0]), 2'h0}))
    else $error("16k sum wrong");

  offset7_ignored_a: assert property (@(posedge clk_i)
    disable iff (!rst_n_q)
    granularity_select |->
      display_memory_address[13:12] == host_address_i[13:12]
      && display_memory_address[21:14] ==
      8'({1'b0, keep_bit15 & host_address_i[15], host_address_i[14]}
         + {1'b0, sel_offset[6:0]}))
    else $error("16k alignment wrong");

  sum_registered_a: assert property (@(posedge clk_i)
    disable iff (!rst_n_q)
    host_req_i |=> display_memory_address_o ==
      $past(display_memory_address))
    else $error("memory address not the sum");

  bit16_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    memory_map_select_q < 2'h2 && !second_offset_enable |->
      u_xlate.intermediate_window_address ==
      {1'b0, host_address_i[15:0]})
    else $error("window bit 16 or 15 wrong in 64k map");

  bit15_forced_a: assert property (@(posedge clk_i)
    disable iff (!rst_n_q)
    (second_offset_enable || !map_64k) |->
      u_xlate.intermediate_window_address[16:15] == 2'h0)
    else $error("window bit 15 not forced low");

  align_4k_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    !granularity_select |-> display_memory_address[21:20] == 2'h0
      && display_memory_address[19:12] ==
      8'({3'h0, u_xlate.intermediate_window_address[16:12]}
         + sel_offset))
    else $error("4k alignment wrong");

  second_sel_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    second_offset_enable && host_address_i[15]
    |-> sel_offset == window_offset_one_q)
    else $error("second offset not selected");

  req_follows_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    host_req_i |=> mem_req_o)
    else $error("request not forwarded");

  ext_reserved_a: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    wr_ext |=> graphics_mode_extension_q[7:6] == 2'h0)
    else $error("reserved bits stored");

  second_window_c: cover property (@(posedge clk_i) disable iff (!rst_n_q)
    host_req_i && use_second);
  gran_16k_c: cover property (@(posedge clk_i) disable iff (!rst_n_q)
    host_req_i && granularity_select);
  bit15_kept_c: cover property (@(posedge clk_i) disable iff (!rst_n_q)
    host_req_i && keep_bit15 && host_address_i[15]);

endmodule

// ### bwo_mem_model.sv
// display memory controller stand-in that counts translated requests
`timescale 1ns/1ps

module bwo_mem_model (
  // clock
  input wire logic clk_i,
  // request from the window
  input wire logic mem_req_i,
  input wire logic [21:0] addr_i,
  // captured
  output logic [21:0] got_addr_o,
  output logic [7:0] got_cnt_o
);
  initial begin
    got_addr_o = 22'h000000;
    got_cnt_o = 8'h00;
  end
  // each request pulse is taken once, at the edge where it is seen
  always @(posedge clk_i) begin
    if (mem_req_i === 1'b1) begin
      got_addr_o <= addr_i;
      got_cnt_o <= got_cnt_o + 8'h01;
    end
  end
endmodule

// ### tb_top.sv
// self-checking bench for the banked window offset block
`timescale 1ns/1ps

module tb_top;
  logic clk_i, rst_n_i, reg_wr, reg_rd, reg_rvalid, host_req, mem_req;
  logic [7:0] reg_index, reg_wdata, reg_rdata, got_cnt, o0, o1, ext, map;
  logic [21:0] host_addr, mem_addr, got_addr;
  int err_count = 0;
  int n_checks = 0;

  // ======
  // instances
  bwo_window u_bwo_window (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_index_i(reg_index),
    .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .reg_rvalid_o(reg_rvalid), .host_req_i(host_req),
    .host_address_i(host_addr), .mem_req_o(mem_req),
    .display_memory_address_o(mem_addr));
  bwo_mem_model u_bwo_mem_model (.clk_i(clk_i), .mem_req_i(mem_req),
    .addr_i(mem_addr), .got_addr_o(got_addr), .got_cnt_o(got_cnt));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ======
  // helpers
  task chk(input logic [21:0] seen, input logic [21:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // expected memory address from the shadow register copies
  function automatic logic [21:0] xl(input logic [21:0] a);
    logic x15;
    logic [7:0] f;
    logic [7:0] g;
    logic [9:0] h;
    x15 = (map[3:2] < 2'h2 && !ext[0]) ? a[15] : 1'b0;
    f = (ext[0] && a[15]) ? o1 : o0;
    g = {4'h0, x15, a[14:12]} + f;
    if (ext[5])
      h = {6'h00, x15, a[14:12]} + {1'b0, f[6:0], 2'h0};
    else
      h = {2'h0, g};
    return {h, a[11:0]};
  endfunction

  task wr(input logic [7:0] i, input logic [7:0] d);
    @(negedge clk_i);
    reg_wr = 1'b1;
    reg_index = i;
    reg_wdata = d;
    @(negedge clk_i);
    reg_wr = 1'b0;
  endtask

  task rd(input logic [7:0] i, input logic [7:0] e);
    @(negedge clk_i);
    reg_rd = 1'b1;
    reg_index = i;
    @(negedge clk_i);
    reg_rd = 1'b0;
    chk({21'h0, reg_rvalid}, 22'h000001);
    chk({14'h0, reg_rdata}, {14'h0, e});
  endtask

  task cfg(input logic [7:0] m, e, a, b);
    wr(8'h06, m);
    wr(8'h0b, e);
    wr(8'h09, a);
    wr(8'h0a, b);
    map = m & 8'h0c;
    ext = e & 8'h3f;
    o0 = a;
    o1 = b;
  endtask

  task req(input logic [21:0] a);
    logic [7:0] c;
    c = got_cnt;
    @(negedge clk_i);
    host_req = 1'b1;
    host_addr = a;
    @(negedge clk_i);
    host_req = 1'b0;
    chk(mem_addr, xl(a));
    chk({21'h0, mem_req}, 22'h000001);
    @(negedge clk_i);
    chk({21'h0, mem_req}, 22'h000000);
    chk({14'h0, got_cnt}, {14'h0, c + 8'h01});
    chk(got_addr, xl(a));
  endtask

  // ======
  // scenarios
  task t_reset;
    rd(8'h06, 8'h00);
    rd(8'h09, 8'h00);
    rd(8'h0a, 8'h00);
    rd(8'h0b, 8'h00);
    req(22'h00a123);
    $display("t_reset done");
  endtask

  task t_regs;
    cfg(8'hff, 8'hff, 8'h5a, 8'ha5);
    rd(8'h06, 8'h0c);
    rd(8'h09, 8'h5a);
    rd(8'h0a, 8'ha5);
    rd(8'h0b, 8'h3f);
    wr(8'h33, 8'h77);
    rd(8'h33, 8'h00);
    $display("t_regs done");
  endtask

  task t_4k;
    cfg(8'h00, 8'h00, 8'h10, 8'h77);
    req(22'h00a123);
    req(22'h0f8fff);
    cfg(8'h00, 8'h00, 8'hff, 8'h00);
    req(22'h0ff000);
    cfg(8'h08, 8'h00, 8'h01, 8'h00);
    req(22'h08abc);
    $display("t_4k done");
  endtask

  task t_second;
    cfg(8'h00, 8'h01, 8'h20, 8'h40);
    req(22'h008123);
    req(22'h000123);
    $display("t_second done");
  endtask

  task t_16k;
    cfg(8'h00, 8'h20, 8'hff, 8'h00);
    req(22'h07f123);
    cfg(8'h04, 8'h21, 8'h00, 8'h81);
    req(22'h00c456);
    cfg(8'h0c, 8'h20, 8'h41, 8'h00);
    req(22'h0fa123);
    $display("t_16k done");
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ======
  // main sequence and watchdog
  initial begin
    rst_n_i = 1'b0;
    {reg_wr, reg_rd, host_req} = 3'h0;
    {reg_index, reg_wdata, o0, o1, ext, map} = 48'h0;
    host_addr = 22'h000000;
    repeat (20) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    t_reset();
    t_regs();
    t_4k();
    t_second();
    t_16k();
    close_out();
  end

  initial begin
    #20000;
    err_count++;
    close_out();
  end
endmodule
